// file: acp_pkg.sv
// Package with register map, field layout, field codes and channel count
//
// Behaviour
// RULE_01: The compare-low register holds the low byte of a 12/10-bit compare value or the whole 8-bit value.
// RULE_02: With compare enabled, each finished conversion compares the stored low byte to result bits 7:0.
// RULE_03: Configuration bit 7 selects high speed (0) or low power (1), the latter lowering the top clock rate.
// RULE_04: Configuration bits 6:5 choose the conversion clock divide: 1, 2, 4 or 8.
// RULE_05: The conversion clock is the selected source divided by the selected ratio.
// RULE_06: Configuration bit 4 selects short (0) or long (1) sample time.
// RULE_07: Configuration bits 3:2 select 8-bit (00), 12-bit (01) or 10-bit (10) resolution; 11 is reserved.
// RULE_08: Configuration bits 1:0 select bus clock, bus clock halved, alternate clock or internal clock.
// RULE_09: Pin-release register one bit n releases channel n pin for channels 0 to 7.
// RULE_10: Pin-release register two releases channels 8 to 15, bit 0 being channel 8.
// RULE_11: Pin-release register three releases channels 16 to 23, bit 0 being channel 16.
// RULE_12: A released pin has its output tristated, input buffer and pullup off, and port reads zero.
// RULE_13: A write to configuration or either compare register aborts a conversion in progress.
// RULE_14: After reset the conversion clock source is the bus clock.
// RULE_15: All six registers are 8-bit read/write, clear at reset, and read back the last value written.
package acp_pkg;
   localparam int ACP_AW = 3;
   localparam logic [2:0] ACP_OFS_CVL = 3'h0;
   localparam logic [2:0] ACP_OFS_CVH = 3'h1;
   localparam logic [2:0] ACP_OFS_CFG = 3'h2;
   localparam logic [2:0] ACP_OFS_PR0 = 3'h3;
   localparam logic [2:0] ACP_OFS_PR1 = 3'h4;
   localparam logic [2:0] ACP_OFS_PR2 = 3'h5;
   localparam logic [7:0] ACP_RST_REG = 8'h00;
   localparam int ACP_BIT_LPC = 7;
   localparam int ACP_BIT_DIV_HI = 6;
   localparam int ACP_BIT_DIV_LO = 5;
   localparam int ACP_BIT_LSMP = 4;
   localparam int ACP_BIT_MODE_HI = 3;
   localparam int ACP_BIT_MODE_LO = 2;
   localparam int ACP_BIT_SRC_HI = 1;
   localparam int ACP_BIT_SRC_LO = 0;
   localparam logic [1:0] ACP_MODE_8 = 2'h0;
   localparam logic [1:0] ACP_MODE_12 = 2'h1;
   localparam logic [1:0] ACP_MODE_10 = 2'h2;
   localparam logic [1:0] ACP_SRC_BUS = 2'h0;
   localparam logic [1:0] ACP_SRC_BUS2 = 2'h1;
   localparam logic [1:0] ACP_SRC_ALT = 2'h2;
   localparam logic [1:0] ACP_SRC_ASYNC = 2'h3;
   localparam int ACP_CH = 24;
endpackage

// file: acp_clk_if.sv
// Interface carrying the clock-select settings and the divided tick
`timescale 1ns/1ns
`default_nettype none
interface acp_clk_if;
   logic [1:0] src;
   logic [1:0] div;
   logic alt_tick;
   logic async_tick;
   logic tick;
   modport ctl (output src, output div, output alt_tick, output async_tick,
      input tick);
   modport gen (input src, input div, input alt_tick, input async_tick,
      output tick);
endinterface
`default_nettype wire

// file: acp_clk_div.sv
// Conversion clock source select and divider, as one-cycle enable pulses
`timescale 1ns/1ns
`default_nettype none
module acp_clk_div
   import acp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   acp_clk_if.gen cif
);
   typedef struct packed {
      logic half;
      logic [2:0] cnt;
      logic tick;
   } acp_div_st_t;
   acp_div_st_t st_r, st_nxt;
   logic src_tick;
   logic [2:0] lim;

   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      st_nxt.half = ~st_r.half;
      // Source pulse chosen by the select field, see RULE_08
      case (cif.src)
         ACP_SRC_BUS: src_tick = 1'b1;
         ACP_SRC_BUS2: src_tick = st_r.half;
         ACP_SRC_ALT: src_tick = cif.alt_tick;
         default: src_tick = cif.async_tick;
      endcase
      // Divide ratio 1, 2, 4 or 8, see RULE_04 and RULE_05
      case (cif.div)
         2'h0: lim = 3'h0;
         2'h1: lim = 3'h1;
         2'h2: lim = 3'h3;
         default: lim = 3'h7;
      endcase
      if (src_tick) begin
         if (st_r.cnt >= lim) begin
            st_nxt.cnt = 3'h0;
            st_nxt.tick = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign cif.tick = st_r.tick;
endmodule
`default_nettype wire

// file: acp_top.sv
// Converter configuration, compare byte and pin release control
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module acp_top
   import acp_pkg::*;
#(
   parameter int CH = ACP_CH
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic alternate_clock,
   input wire logic internal_async_clock,
   input wire logic compare_enable,
   input wire logic conv_done,
   input wire logic [7:0] conv_result_low,
   output logic compare_low_match,
   output logic conversion_abort,
   output logic conversion_clock,
   output logic low_power_select,
   output logic long_sample_select,
   output logic [1:0] resolution_mode,
   input wire logic [CH-1:0] port_out,
   input wire logic [CH-1:0] port_dir,
   input wire logic [CH-1:0] port_pullup,
   input wire logic [CH-1:0] pin_in,
   output logic [CH-1:0] pin_out,
   output logic [CH-1:0] pin_oe_n,
   output logic [CH-1:0] pin_pullup,
   output logic [CH-1:0] port_read
);
   typedef struct packed {
      logic [7:0] cvl;
      logic [7:0] cvh;
      logic [7:0] cfg;
      logic [CH-1:0] rel;
      logic [7:0] rdata;
      logic match;
      logic abort;
      logic tick;
      logic [CH-1:0] pout;
      logic [CH-1:0] poe_n;
      logic [CH-1:0] ppu;
      logic [CH-1:0] prd;
   } acp_st_t;
   acp_st_t st_r, st_nxt;
   acp_clk_if cif ();

   acp_clk_div u_div (
      .ref_clk(ref_clk),
      .reset(reset),
      .cif(cif)
   );

   assign cif.src = st_r.cfg[ACP_BIT_SRC_HI:ACP_BIT_SRC_LO];
   assign cif.div = st_r.cfg[ACP_BIT_DIV_HI:ACP_BIT_DIV_LO];
   assign cif.alt_tick = alternate_clock;
   assign cif.async_tick = internal_async_clock;

   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = 8'h00;
      st_nxt.abort = 1'b0;
      st_nxt.tick = cif.tick;
      // Register writes, see RULE_15
      if (wr) begin
         if (addr == ACP_OFS_CVL) begin
            st_nxt.cvl = wdata;
            st_nxt.abort = 1'b1;
         end else if (addr == ACP_OFS_CVH) begin
            st_nxt.cvh = wdata;
            st_nxt.abort = 1'b1;
         end else if (addr == ACP_OFS_CFG) begin
            // see RULE_03, see RULE_06, see RULE_07
            st_nxt.cfg = wdata;
            st_nxt.abort = 1'b1;
         end else if (addr == ACP_OFS_PR0) begin
            st_nxt.rel[7:0] = wdata; // see RULE_09
         end else if (addr == ACP_OFS_PR1) begin
            st_nxt.rel[15:8] = wdata; // see RULE_10
         end else if (addr == ACP_OFS_PR2) begin
            st_nxt.rel[23:16] = wdata; // see RULE_11
         end
      end
      // A write to configuration or either compare register aborts any running conversion, see RULE_13
      // Reads answer in the next cycle; unmapped reads return zero
      if (rd) begin
         if (addr == ACP_OFS_CVL) begin
            st_nxt.rdata = st_r.cvl;
         end else if (addr == ACP_OFS_CVH) begin
            st_nxt.rdata = st_r.cvh;
         end else if (addr == ACP_OFS_CFG) begin
            st_nxt.rdata = st_r.cfg;
         end else if (addr == ACP_OFS_PR0) begin
            st_nxt.rdata = st_r.rel[7:0];
         end else if (addr == ACP_OFS_PR1) begin
            st_nxt.rdata = st_r.rel[15:8];
         end else if (addr == ACP_OFS_PR2) begin
            st_nxt.rdata = st_r.rel[23:16];
         end
      end
      // A finishing conversion outranks a clearing write in one cycle
      if (st_nxt.abort) begin
         st_nxt.match = 1'b0; // see RULE_13
      end
      // Low-byte compare in every resolution, see RULE_01 and RULE_02
      if (conv_done) begin
         st_nxt.match = compare_enable && (conv_result_low == st_r.cvl);
      end
      // Released pins float, lose pullup and read zero, see RULE_12
      for (int i = 0; i < CH; i++) begin
         st_nxt.pout[i] = st_r.rel[i] ? 1'b0 : port_out[i];
         st_nxt.poe_n[i] = st_r.rel[i] ? 1'b1 : ~port_dir[i];
         st_nxt.ppu[i] = st_r.rel[i] ? 1'b0 : port_pullup[i];
         st_nxt.prd[i] = st_r.rel[i] ? 1'b0 : pin_in[i];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r <= '0; // see RULE_14, see RULE_15
         st_r.poe_n <= '1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata = st_r.rdata;
   assign compare_low_match = st_r.match;
   assign conversion_abort = st_r.abort;
   assign conversion_clock = st_r.tick;
   assign low_power_select = st_r.cfg[ACP_BIT_LPC];
   assign long_sample_select = st_r.cfg[ACP_BIT_LSMP];
   assign resolution_mode = st_r.cfg[ACP_BIT_MODE_HI:ACP_BIT_MODE_LO];
   assign pin_out = st_r.pout;
   assign pin_oe_n = st_r.poe_n;
   assign pin_pullup = st_r.ppu;
   assign port_read = st_r.prd;
endmodule
`default_nettype wire

// file: acp_top_props.sv
// Checker for register side effects and the compare result
`timescale 1ns/1ns
`default_nettype none
module acp_top_props
   import acp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic compare_enable,
   input wire logic conv_done,
   input wire logic [7:0] conv_result_low,
   input wire logic compare_low_match,
   input wire logic conversion_abort,
   input wire logic low_power_select,
   input wire logic long_sample_select,
   input wire logic [1:0] resolution_mode
);
   logic [7:0] cvl_r;
   logic cw, q;
   assign cw = wr && addr == ACP_OFS_CFG;
   // Quiet cycle: no write now and no abort landing
   assign q = !wr && !conversion_abort;
   always_ff @(posedge ref_clk) begin
      if (reset) cvl_r <= 8'h00;
      else if (wr && addr == ACP_OFS_CVL) cvl_r <= wdata;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   a_abort_on_write: assert property (##1 conversion_abort ==
      $past(wr && addr <= ACP_OFS_CFG)) else $error("abort pulse wrong");
   a_lowpower_field: assert property (cw |=> low_power_select ==
      $past(wdata[ACP_BIT_LPC])) else $error("low power field wrong");
   a_sample_field: assert property (cw |=> long_sample_select ==
      $past(wdata[ACP_BIT_LSMP])) else $error("sample field wrong");
   a_mode_field: assert property (cw |=> resolution_mode ==
      $past(wdata[3:2])) else $error("mode field wrong");
   a_fields_held: assert property (!cw |=> $stable({low_power_select,
      long_sample_select, resolution_mode})) else $error("fields changed");
   a_read_idle: assert property (!rd |=> rdata == 8'h00)
      else $error("rdata outside read");
   a_match_update: assert property (conv_done && q |=>
      compare_low_match == $past(compare_enable && conv_result_low == cvl_r))
      else $error("match wrong");
   a_match_held: assert property (!conv_done && q |=>
      $stable(compare_low_match)) else $error("match changed");
   a_abort_clears: assert property (wr && addr <= ACP_OFS_CFG &&
      !conv_done |=> !compare_low_match) else $error("match not cleared");
   c_compare: cover property (conv_done && compare_enable);
   c_cfg: cover property (cw);
   c_read: cover property (rd ##1 rdata != 8'h00);
endmodule
bind acp_top acp_top_props u_props (.*);
`default_nettype wire

// file: test_adc_config_and_pin_control.sv
// Testbench for configuration, compare and pin release
`timescale 1ns/1ns
`default_nettype none
module test_adc_config_and_pin_control;
   import acp_pkg::*;
   logic ref_clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
   logic alt = 1'b0, asy = 1'b0, cen = 1'b0, done = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00, res = 8'h00, cyc = 8'h00, rdata;
   logic [23:0] pv = 24'h00_0000, pout, oen, pup, prd;
   logic [23:0] mask = 24'h81_3CA5;
   logic match, abort, cclk, lp, ls;
   logic [1:0] mode;
   int n_errors = 0, num_checks = 0;
   acp_top dut (.ref_clk(ref_clk), .reset(reset), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .alternate_clock(alt), .internal_async_clock(asy),
      .compare_enable(cen), .conv_done(done), .conv_result_low(res),
      .compare_low_match(match), .conversion_abort(abort),
      .conversion_clock(cclk), .low_power_select(lp),
      .long_sample_select(ls), .resolution_mode(mode), .port_out(pv),
      .port_dir(~pv), .port_pullup(pv), .pin_in(~pv), .pin_out(pout),
      .pin_oe_n(oen), .pin_pullup(pup), .port_read(prd));
   always #25 ref_clk = ~ref_clk;
   // Alternate source ticks every 4 cycles, internal one every 8
   always @(posedge ref_clk) begin
      cyc <= cyc + 8'h01;
      alt <= cyc[1:0] == 2'h3;
      asy <= cyc[2:0] == 3'h7;
   end
   task automatic check(input string nm, input logic [23:0] s, e);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 check("rdata", 24'(rdata), 24'(e));
   endtask
   task automatic conv(input logic [7:0] r, input logic e);
      @(posedge ref_clk);
      res <= r;
      done <= 1'b1;
      @(posedge ref_clk);
      done <= 1'b0;
      #1 check("match", 24'(match), 24'(e));
   endtask
   // Counts conversion clock pulses over 64 settled cycles
   task automatic ticks(input int e);
      int n;
      n = 0;
      repeat (20) @(posedge ref_clk);
      repeat (64) begin
         @(posedge ref_clk);
         #1 n += int'(cclk === 1'b1);
      end
      check("ticks", 24'(n), 24'(e));
   endtask
   initial begin
      #1_000_000;
      n_errors++;
      end_of_test();
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      for (int a = 0; a < 8; a++) rd_reg(3'(a), 8'h00);
      ticks(64);
      for (int a = 0; a < 8; a++) wr_reg(3'(a), 8'(8'h11 * (a + 1)));
      for (int a = 0; a < 8; a++)
         rd_reg(3'(a), a < 6 ? 8'(8'h11 * (a + 1)) : 8'h00);
      for (int s = 0; s < 4; s++) begin
         for (int d = 0; d < 4; d++) begin
            wr_reg(ACP_OFS_CFG, 8'((d << 5) | s));
            ticks(64 >> (s + d));
         end
      end
      wr_reg(ACP_OFS_CVL, 8'hA5);
      cen <= 1'b1;
      for (int m = 0; m < 3; m++) begin
         wr_reg(ACP_OFS_CFG, 8'h90 | 8'(m << 2));
         #1 check("cfg", 24'({lp, ls, mode}), 24'({2'h3, 2'(m)}));
         check("abort", 24'(abort), 24'h00_0001);
         check("cleared", 24'(match), 24'h00_0000);
         conv(8'hA4, 1'b0);
         conv(8'hA5, 1'b1);
      end
      cen <= 1'b0;
      conv(8'hA5, 1'b0);
      wr_reg(ACP_OFS_PR0, 8'hA5);
      wr_reg(ACP_OFS_PR1, 8'h3C);
      wr_reg(ACP_OFS_PR2, 8'h81);
      for (int i = 0; i < 2; i++) begin
         @(posedge ref_clk);
         pv <= i == 0 ? 24'hFF_FFFF : 24'h5A_5A5A;
         repeat (2) @(posedge ref_clk);
         #1 check("oe_n", oen, mask | pv);
         check("out", pout, pv & ~mask);
         check("pullup", pup, pv & ~mask);
         check("read", prd, ~pv & ~mask);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
